/* File: logic/transmit_channel_controller.sv */
`timescale 1ns/1ps
module transmit_channel_controller
  import payload_ctl_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  payload_bus_if.device    bus,
  input  wire logic        slot_valid,
  input  wire logic [4:0]  slot_index,
  input  wire logic [7:0]  transmit_serial_data_in,
  input  wire logic [3:0]  transmit_signaling_in,
  input  wire logic        signaling_frame,
  input  wire logic [7:0]  loop_data_in,
  input  wire logic        rx_clock_master,
  input  wire logic        tx_clock_slave,
  input  wire logic        clocks_identical,
  input  wire logic        pattern_direction_select,
  input  wire logic [7:0]  pattern_gen_data,
  output logic             pattern_gen_take,
  output logic             check_valid,
  output logic [7:0]       check_data,
  output logic             slot_valid_out,
  output logic [7:0]       slot_data_out,
  output logic [3:0]       slot_sig_out
);
  import payload_ctl_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b01,
    ACC_BUSY = 2'b10
  } acc_state_t;

  typedef struct packed {
    acc_state_t                 acc;
    logic                       enable;
    logic                       rnw;
    logic [6:0]                 iaddr;
    logic [7:0]                 dbuf;
    logic [7:0]                 cnt;
    logic [7:0]                 rdata;
    logic [2:0]                 mw_phase;
    logic                       out_valid;
    logic [7:0]                 out_data;
    logic [3:0]                 out_sig;
    logic                       chk_valid;
    logic [7:0]                 chk_data;
    logic [IND_DEPTH-1:0][7:0]  mem;
  } state_t;

  state_t s_reg;
  state_t s_next;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic addr_ok(input logic [6:0] a);
    addr_ok = (a >= IND_FIRST) && (a <= IND_LAST);
  endfunction

  function automatic logic [7:0] invert_byte(input logic [7:0] d, input logic full,
                                             input logic sign);
    case ({full, sign})
      2'b01:   invert_byte = d ^ 8'h80;
      2'b10:   invert_byte = ~d;
      2'b11:   invert_byte = d ^ 8'h7F;
      default: invert_byte = d;
    endcase
  endfunction

  // bit 8 of a channel is the lsb, bit 7 the next one up
  function automatic logic [7:0] zero_suppress(input logic [7:0] d, input zcs_mode_t m,
                                               input logic sig_frame);
    logic [7:0] r;
    r = d;
    case (m)
      ZCS_FORCE8: r[0] = 1'b1;
      ZCS_GTE:
      begin
        if (d == 8'h00)
        begin
          if (sig_frame)
            r[1] = 1'b1;
          else
            r[0] = 1'b1;
        end
      end
      ZCS_BELL:
      begin
        if (d == 8'h00)
          r[1] = 1'b1;
      end
      default: r = d;
    endcase
    zero_suppress = r;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [7:0] ctl;
  logic [7:0] idle_b;
  logic [7:0] sig_b;
  logic [7:0] d;
  logic [3:0] sg;
  logic       loop_ok;
  logic       in_range;
  logic       take;
  logic [6:0] widx;

  always_comb
  begin
    s_next   = s_reg;
    take     = 1'b0;
    in_range = (slot_index < 5'(NUM_CH));
    ctl      = s_reg.mem[in_range ? slot_index : 5'h00];
    idle_b   = s_reg.mem[IDLE_BANK + int'(in_range ? slot_index : 5'h00)];
    sig_b    = s_reg.mem[SIG_BANK + int'(in_range ? slot_index : 5'h00)];
    widx     = bus.reg_wdata[6:0] - IND_FIRST;
    // loop only where the elastic store or a shared clock can align it
    loop_ok  = rx_clock_master || (tx_clock_slave && clocks_identical);

    // register reads answer one cycle later
    if (bus.reg_rd)
    begin
      case (bus.reg_addr)
        CFG_OFS:  s_next.rdata = {7'h00, s_reg.enable};
        STAT_OFS: s_next.rdata = {s_reg.acc == ACC_BUSY, 7'h00};
        ACTL_OFS: s_next.rdata = {s_reg.rnw, s_reg.iaddr};
        DBUF_OFS: s_next.rdata = s_reg.dbuf;
        default:  s_next.rdata = 8'h00;
      endcase
    end

    if (bus.reg_wr && (bus.reg_addr == CFG_OFS))
      s_next.enable = bus.reg_wdata[ENABLE_BIT];

    case (s_reg.acc)
      ACC_IDLE:
      begin
        if (bus.reg_wr && (bus.reg_addr == DBUF_OFS))
          s_next.dbuf = bus.reg_wdata;
        if (bus.reg_wr && (bus.reg_addr == ACTL_OFS))
        begin
          s_next.rnw   = bus.reg_wdata[RNW_BIT];
          s_next.iaddr = bus.reg_wdata[6:0];
          if (addr_ok(bus.reg_wdata[6:0]))
          begin
            s_next.acc = ACC_BUSY;
            s_next.cnt = 8'h00;
            if (!bus.reg_wdata[RNW_BIT])
              s_next.mem[widx] = s_reg.dbuf;
          end
        end
      end
      ACC_BUSY:
      begin
        // buffer and command writes are dropped while busy
        s_next.cnt = s_reg.cnt + 8'h01;
        if (s_reg.rnw && (s_reg.cnt == READ_CYC - 8'h01))
          s_next.dbuf = s_reg.mem[s_reg.iaddr - IND_FIRST];
        if (s_reg.cnt == ACCESS_CYC - 8'h01)
          s_next.acc = ACC_IDLE;
      end
      default: s_next.acc = ACC_IDLE;
    endcase

    // payload path, lowest priority applied first so higher ones overwrite
    d  = transmit_serial_data_in;
    sg = transmit_signaling_in;
    s_next.chk_valid = 1'b0;
    if (s_reg.enable && in_range && slot_valid)
    begin
      if (ctl[TEST_BIT] && pattern_direction_select)
      begin
        s_next.chk_valid = 1'b1;
        s_next.chk_data  = transmit_serial_data_in;
      end
      else
      begin
        d = invert_byte(d, ctl[INV_BIT], ctl[SIGN_BIT]);
        if (ctl[IDLE_BIT])
          d = idle_b;
        if (ctl[TEST_BIT])
          d = pattern_gen_data;
        if (ctl[MW_BIT])
          d = MW_SEQ[s_reg.mw_phase];
        if (ctl[LOOP_BIT] && loop_ok)
          d = loop_data_in;
        // generator advances only on slots that really carry its bytes
        take = ctl[TEST_BIT] && !ctl[MW_BIT] && !(ctl[LOOP_BIT] && loop_ok);
        d = zero_suppress(d, zcs_mode_t'(ctl[1:0]), signaling_frame);
      end
      if (sig_b[REPL_BIT])
        sg = sig_b[SRC_BIT] ? sig_b[3:0] : transmit_signaling_in;
    end
    if (slot_valid && (slot_index == 5'(NUM_CH - 1)))
      s_next.mw_phase = s_reg.mw_phase + 3'h1;
    s_next.out_valid = slot_valid;
    if (slot_valid)
    begin
      s_next.out_data = d;
      s_next.out_sig  = sg;
    end

    if (!rst_b)
    begin
      s_next          = '0;
      s_next.acc      = ACC_IDLE;
      s_next.enable   = CFG_RST[ENABLE_BIT];
      s_next.rnw      = ACTL_RST[RNW_BIT];
      s_next.iaddr    = ACTL_RST[6:0];
      s_next.dbuf     = DBUF_RST;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    s_reg <= s_next;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign bus.reg_rdata      = s_reg.rdata;
  assign pattern_gen_take   = take;
  assign check_valid        = s_reg.chk_valid;
  assign check_data         = s_reg.chk_data;
  assign slot_valid_out     = s_reg.out_valid;
  assign slot_data_out      = s_reg.out_data;
  assign slot_sig_out       = s_reg.out_sig;
endmodule

/* File: logic/payload_ctl_pkg.sv */
package payload_ctl_pkg;
  // ----------------------------------------
  // device register offsets and fields
  // ----------------------------------------
  localparam logic [7:0] CFG_OFS    = 8'h30;
  localparam logic [7:0] STAT_OFS   = 8'h31;
  localparam logic [7:0] ACTL_OFS   = 8'h32;
  localparam logic [7:0] DBUF_OFS   = 8'h33;
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] ACTL_RST   = 8'h00;
  localparam logic [7:0] DBUF_RST   = 8'h00;
  localparam int         ENABLE_BIT = 0;
  localparam int         BUSY_BIT   = 7;
  localparam int         RNW_BIT    = 7;
  // ----------------------------------------
  // indirect space
  // ----------------------------------------
  localparam logic [6:0] IND_FIRST  = 7'h01;
  localparam logic [6:0] IND_LAST   = 7'h48;
  localparam int         NUM_CH     = 24;
  localparam int         IND_DEPTH  = 72;
  localparam int         IDLE_BANK  = 24;
  localparam int         SIG_BANK   = 48;
  localparam int         INV_BIT    = 7;
  localparam int         IDLE_BIT   = 6;
  localparam int         MW_BIT     = 5;
  localparam int         SIGN_BIT   = 4;
  localparam int         TEST_BIT   = 3;
  localparam int         LOOP_BIT   = 2;
  localparam int         SRC_BIT    = 7;
  localparam int         REPL_BIT   = 6;
  typedef enum logic [1:0] {
    ZCS_NONE   = 2'h0,
    ZCS_FORCE8 = 2'h1,
    ZCS_GTE    = 2'h2,
    ZCS_BELL   = 2'h3
  } zcs_mode_t;
  localparam logic [7:0][7:0] MW_SEQ = {8'h9E, 8'h8B, 8'h8B, 8'h9E,
                                        8'h1E, 8'h0B, 8'h0B, 8'h1E};
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int         CLK_NS     = 5;
  localparam int         ACCESS_NS  = 650;
  localparam int         READ_NS    = 490;
  localparam logic [7:0] ACCESS_CYC = 8'(ACCESS_NS / CLK_NS);
  localparam logic [7:0] READ_CYC   = 8'(READ_NS / CLK_NS);
  // ----------------------------------------
  // host controller map (AHB-Lite)
  // ----------------------------------------
  localparam logic [7:0] H_ADDR_OFS = 8'h00;
  localparam logic [7:0] H_DATA_OFS = 8'h04;
  localparam logic [7:0] H_CMD_OFS  = 8'h08;
  localparam logic [7:0] H_STAT_OFS = 8'h0C;
  typedef enum logic [1:0] {
    OP_DWR = 2'h0,
    OP_DRD = 2'h1,
    OP_IWR = 2'h2,
    OP_IRD = 2'h3
  } host_op_t;
endpackage

/* File: logic/payload_bus_if.sv */
`timescale 1ns/1ps
interface payload_bus_if;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  modport device (input reg_addr, input reg_wr, input reg_rd, input reg_wdata,
                  output reg_rdata);
  modport host   (output reg_addr, output reg_wr, output reg_rd, output reg_wdata,
                  input reg_rdata);
endinterface

/* File: logic/payload_host_ctl.sv */
`timescale 1ns/1ps
module payload_host_ctl
  import payload_ctl_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  payload_bus_if.host      bus,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  import payload_ctl_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [5:0] {
    H_IDLE   = 6'b000001,
    H_DIRECT = 6'b000010,
    H_GET    = 6'b000100,
    H_POLL   = 6'b001000,
    H_CHECK  = 6'b010000,
    H_CTRL   = 6'b100000
  } host_state_t;

  typedef struct packed {
    host_state_t fsm;
    host_op_t    op;
    logic        second;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  result;
    logic        wr_pend;
    logic [7:0]  wofs;
    logic [31:0] rdata;
    logic [7:0]  bus_addr;
    logic        bus_wr;
    logic        bus_rd;
    logic [7:0]  bus_wdata;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic   take_addr;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_next        = s_reg;
    s_next.bus_wr = 1'b0;
    s_next.bus_rd = 1'b0;
    take_addr     = hsel && htrans[1] && hready;

    // write data lands in the data phase; commands are ignored while busy
    if (s_reg.wr_pend)
    begin
      case (s_reg.wofs)
        H_ADDR_OFS: s_next.addr  = hwdata[7:0];
        H_DATA_OFS: s_next.wdata = hwdata[7:0];
        default: s_next.addr = s_reg.addr;
      endcase
    end
    s_next.wr_pend = take_addr && hwrite;
    s_next.wofs    = haddr[7:0];
    if (take_addr && !hwrite)
    begin
      case (haddr[7:0])
        H_ADDR_OFS: s_next.rdata = {24'h000000, s_reg.addr};
        H_DATA_OFS: s_next.rdata = {24'h000000, s_reg.wdata};
        H_STAT_OFS: s_next.rdata = {16'h0000, s_reg.result, 7'h00, s_reg.fsm != H_IDLE};
        default:    s_next.rdata = 32'h00000000;
      endcase
    end

    case (s_reg.fsm)
      H_IDLE:
      begin
        // a command is decoded only from idle, so one written while busy is dropped
        if (s_reg.wr_pend && (s_reg.wofs == H_CMD_OFS))
        begin
          s_next.op     = host_op_t'(hwdata[1:0]);
          s_next.second = 1'b0;
          s_next.fsm    = hwdata[1] ? H_POLL : H_DIRECT;
        end
      end
      H_DIRECT:
      begin
        s_next.bus_addr  = s_reg.addr;
        s_next.bus_wdata = s_reg.wdata;
        s_next.bus_wr    = (s_reg.op == OP_DWR);
        s_next.bus_rd    = (s_reg.op == OP_DRD);
        s_next.fsm       = (s_reg.op == OP_DRD) ? H_GET : H_IDLE;
      end
      H_GET:
      begin
        // read data stands only from the cycle after the strobe
        if (!s_reg.bus_rd)
        begin
          s_next.result = bus.reg_rdata;
          s_next.fsm    = H_IDLE;
        end
      end
      H_POLL:
      begin
        s_next.bus_addr = STAT_OFS;
        s_next.bus_rd   = 1'b1;
        s_next.fsm      = H_CHECK;
      end
      H_CHECK:
      begin
        if (s_reg.bus_rd)
          s_next.fsm = H_CHECK;
        else if (bus.reg_rdata[BUSY_BIT])
          s_next.fsm = H_POLL;
        else if (s_reg.second)
        begin
          s_next.bus_addr = DBUF_OFS;
          s_next.bus_rd   = 1'b1;
          s_next.fsm      = H_GET;
        end
        else
        begin
          // buffer first, command next cycle
          s_next.bus_addr  = DBUF_OFS;
          s_next.bus_wdata = s_reg.wdata;
          s_next.bus_wr    = (s_reg.op == OP_IWR);
          s_next.fsm       = H_CTRL;
        end
      end
      H_CTRL:
      begin
        s_next.bus_addr  = ACTL_OFS;
        s_next.bus_wdata = {s_reg.op == OP_IRD, s_reg.addr[6:0]};
        s_next.bus_wr    = 1'b1;
        s_next.second    = (s_reg.op == OP_IRD);
        s_next.fsm       = (s_reg.op == OP_IRD) ? H_POLL : H_IDLE;
      end
      default: s_next.fsm = H_IDLE;
    endcase

    if (!rst_b)
    begin
      s_next     = '0;
      s_next.fsm = H_IDLE;
      s_next.op  = OP_DWR;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    s_reg <= s_next;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = s_reg.rdata;
  assign bus.reg_addr  = s_reg.bus_addr;
  assign bus.reg_wr    = s_reg.bus_wr;
  assign bus.reg_rd    = s_reg.bus_rd;
  assign bus.reg_wdata = s_reg.bus_wdata;
endmodule

/* File: verification/payload_link_chk.sv */
`timescale 1ns/1ps
module payload_link_chk
  import payload_ctl_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // ----------------------------------------
  // shadow of the device registers
  // ----------------------------------------
  logic [7:0] cnt_reg;
  logic [7:0] cfg_reg;
  logic [7:0] actl_reg;
  logic [7:0] dbuf_reg;
  logic [7:0] mem_reg [IND_DEPTH];
  logic       idle;
  logic       cmd_ok;
  logic [6:0] idx;
  // the counter saturates at ff, which also stands for no access since reset
  assign idle   = cnt_reg > 8'd130;
  assign idx    = reg_wdata[6:0] - 7'h01;
  assign cmd_ok = reg_wr && reg_addr == ACTL_OFS && idle && reg_wdata[6:0] >= IND_FIRST
                  && reg_wdata[6:0] <= IND_LAST;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      cnt_reg  <= 8'hFF;
      cfg_reg  <= 8'h00;
      actl_reg <= 8'h00;
      dbuf_reg <= 8'h00;
      for (int i = 0; i < IND_DEPTH; i++)
        mem_reg[i] <= 8'h00;
    end
    else
    begin
      if (cmd_ok) cnt_reg <= 8'h01;
      else if (cnt_reg != 8'hFF) cnt_reg <= cnt_reg + 8'h01;
      if (reg_wr && reg_addr == CFG_OFS) cfg_reg <= reg_wdata;
      if (reg_wr && reg_addr == ACTL_OFS && idle) actl_reg <= reg_wdata;
      if (reg_wr && reg_addr == DBUF_OFS && idle) dbuf_reg <= reg_wdata;
      if (cmd_ok && !reg_wdata[RNW_BIT]) mem_reg[idx] <= dbuf_reg;
      if (cmd_ok && reg_wdata[RNW_BIT]) dbuf_reg <= mem_reg[idx];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_dbuf_load;
    reg_wr && reg_addr == DBUF_OFS;
  endsequence
  sequence s_ind_wr;
    s_dbuf_load ##1 (cmd_ok && !reg_wdata[RNW_BIT]);
  endsequence
  property p_busy_high;
    reg_rd && reg_addr == STAT_OFS && cnt_reg >= 8'd2 && cnt_reg <= 8'd129 |=> reg_rdata[BUSY_BIT];
  endproperty
  property p_busy_low;
    reg_rd && reg_addr == STAT_OFS && cnt_reg >= 8'd132 |=> !reg_rdata[BUSY_BIT];
  endproperty
  property p_no_early;
    reg_wr && (reg_addr == ACTL_OFS || reg_addr == DBUF_OFS) |-> cnt_reg > 8'd130;
  endproperty
  property p_wr_order;
    cmd_ok && !reg_wdata[RNW_BIT] |-> $past(reg_wr) && $past(reg_addr) == DBUF_OFS;
  endproperty
  property p_wr_quiet;
    s_ind_wr |=> (!(reg_wr && (reg_addr == ACTL_OFS || reg_addr == DBUF_OFS)))[*8];
  endproperty
  property p_poll;
    cmd_ok |-> ##[1:140] (reg_rd && reg_addr == STAT_OFS);
  endproperty
  property p_cfg_back;
    reg_rd && reg_addr == CFG_OFS |=> reg_rdata[ENABLE_BIT] == cfg_reg[ENABLE_BIT];
  endproperty
  property p_actl_back;
    reg_rd && reg_addr == ACTL_OFS |=> reg_rdata == actl_reg;
  endproperty
  property p_dbuf;
    reg_rd && reg_addr == DBUF_OFS && cnt_reg >= 8'd99 |=> reg_rdata == dbuf_reg;
  endproperty
  a_busy_high: assert property (p_busy_high) else $error("busy not set during access");
  a_busy_low: assert property (p_busy_low) else $error("busy still set after access");
  a_no_early: assert property (p_no_early) else $error("access started while busy");
  a_wr_order: assert property (p_wr_order) else $error("write command without data");
  a_wr_quiet: assert property (p_wr_quiet) else $error("access right after write");
  a_poll: assert property (p_poll) else $error("no status poll after command");
  a_cfg_back: assert property (p_cfg_back) else $error("enable bit readback wrong");
  a_actl_back: assert property (p_actl_back) else $error("address/control readback wrong");
  a_dbuf: assert property (p_dbuf) else $error("data buffer content wrong");
endmodule

/* File: verification/transmit_per_channel_payload_control_tb.sv */
`timescale 1ns/1ps
module transmit_per_channel_payload_control_tb;
  import payload_ctl_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout, hresp, take, cv, ov;
  logic [31:0] hrdata, v;
  logic        sv = 1'b0, sf = 1'b0, rxm = 1'b0, txs = 1'b0, same = 1'b0, dir = 1'b0;
  logic [4:0]  si = 5'h0;
  logic [7:0]  din = 8'h0, lp = 8'h0, gen = 8'h0, cd, od, c, s, ed, ecd;
  logic [3:0]  sig = 4'h0, os, es;
  logic        ev = 1'b0, ecv = 1'b0, esv = 1'b0, etake, en_m = 1'b0;
  logic [7:0]  ctl_m [IND_DEPTH];
  logic [6:0]  edge_l [6] = '{7'h01, 7'h18, 7'h19, 7'h30, 7'h31, 7'h48};
  logic [7:0]  ofs_l [4] = '{CFG_OFS, STAT_OFS, ACTL_OFS, DBUF_OFS};
  int          n_mismatch = 0, compares = 0, seed = 32'hfdac, mw_ph = 0;
  always #2.5 clk_sys = ~clk_sys;
  payload_bus_if bus_link ();
  payload_host_ctl payload_host_ctl_i (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus_link),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  transmit_channel_controller transmit_channel_controller_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .bus(bus_link), .slot_valid(sv), .slot_index(si), .transmit_serial_data_in(din),
    .transmit_signaling_in(sig), .signaling_frame(sf), .loop_data_in(lp), .rx_clock_master(rxm),
    .tx_clock_slave(txs), .clocks_identical(same), .pattern_direction_select(dir),
    .pattern_gen_data(gen), .pattern_gen_take(take), .check_valid(cv), .check_data(cd),
    .slot_valid_out(ov), .slot_data_out(od), .slot_sig_out(os));
  payload_link_chk payload_link_chk_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(bus_link.reg_addr), .reg_wr(bus_link.reg_wr), .reg_rd(bus_link.reg_rd),
    .reg_wdata(bus_link.reg_wdata), .reg_rdata(bus_link.reg_rdata));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // every host operation ends by polling, since the link refuses overlapping accesses
  task automatic hop(input host_op_t op, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    ahb(1'b1, {24'h0, H_ADDR_OFS}, {24'h0, a}, r);
    ahb(1'b1, {24'h0, H_DATA_OFS}, {24'h0, d}, r);
    ahb(1'b1, {24'h0, H_CMD_OFS}, {30'h0, op}, r);
    for (int i = 0; i < 200 && (i == 0 || r[0] !== 1'b0); i++)
      ahb(1'b0, {24'h0, H_STAT_OFS}, 32'h0, r);
    chk("status busy", 32'h0, {31'h0, r[0]});
    r = {24'h0, r[15:8]};
  endtask
  task automatic ind_wr(input logic [6:0] a, input logic [7:0] d);
    ctl_m[a - 7'h01] = d;
    hop(OP_IWR, {1'b0, a}, d, v);
  endtask
  task automatic slots(input int n);
    logic [31:0] r1, r2;
    repeat (n)
    begin
      @(posedge clk_sys);
      r1 = $random(seed);
      r2 = $random(seed);
      sv <= r1[0];
      si <= r1[5:1];
      din <= (r1[7:6] == 2'h0) ? 8'h00 : r1[15:8];
      {same, txs, rxm, sf, sig} <= r1[23:16];
      dir <= r1[24];
      lp <= r1[25] ? r2[7:0] : 8'h00;
      gen <= r1[26] ? r2[15:8] : 8'h00;
    end
    @(posedge clk_sys);
    sv <= 1'b0;
  endtask
  // ----------------------------------------
  // slot model, judged away from the clock edge
  // ----------------------------------------
  always @(negedge clk_sys)
  if (rst_b)
  begin
    chk("slot_valid_out", {31'h0, ev}, {31'h0, ov});
    if (ev) chk("slot_data_out", {24'h0, ed}, {24'h0, od});
    chk("check_valid", {31'h0, ecv}, {31'h0, cv});
    if (ecv) chk("check_data", {24'h0, ecd}, {24'h0, cd});
    if (esv) chk("slot_sig_out", {28'h0, es}, {28'h0, os});
    ev = sv;
    ecv = 1'b0;
    esv = sv;
    es = sig;
    etake = 1'b0;
    ed = din;
    if (sv && en_m && si < 5'd24)
    begin
      c = ctl_m[si];
      s = ctl_m[SIG_BANK + si];
      if (c[INV_BIT] || c[SIGN_BIT]) ed = din ^ {c[SIGN_BIT] ^ c[INV_BIT], {7{c[INV_BIT]}}};
      if (c[IDLE_BIT]) ed = ctl_m[IDLE_BANK + si];
      if (c[TEST_BIT] && !dir) {etake, ed} = {1'b1, gen};
      if (c[MW_BIT]) {etake, ed} = {1'b0, MW_SEQ[mw_ph]};
      if (c[LOOP_BIT] && (rxm || (txs && same))) {etake, ed} = {1'b0, lp};
      if (c[1:0] == ZCS_FORCE8 || (c[1:0] == ZCS_GTE && ed == 8'h00 && !sf)) ed[0] = 1'b1;
      else if (ed == 8'h00 && (c[1:0] == ZCS_BELL || c[1:0] == ZCS_GTE)) ed[1] = 1'b1;
      if (c[TEST_BIT] && dir) {ecv, ecd, ed} = {1'b1, din, din};
      if (s[REPL_BIT]) {esv, es} = {1'b1, s[SRC_BIT] ? s[3:0] : sig};
    end
    if (sv && si == 5'd23) mw_ph = (mw_ph + 1) % 8;
    chk("pattern_gen_take", {31'h0, etake}, {31'h0, take});
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < IND_DEPTH; i++)
      ctl_m[i] = 8'h00;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      hop(OP_DRD, ofs_l[i], 8'h00, v);
      chk("reset value", 32'h0, v);
    end
    ahb(1'b0, 32'h10, 32'h0, v);
    chk("unmapped read", 32'h0, v);
    hop(OP_IRD, 8'h05, 8'h00, v);
    chk("indirect reset", 32'h0, v);
    $display("test reset values done");
    for (int i = 0; i < 6; i++)
      ind_wr(edge_l[i], 8'($random(seed)));
    for (int i = 0; i < 6; i++)
    begin
      hop(OP_IRD, {1'b1, edge_l[i]}, 8'h00, v);
      chk("indirect readback", {24'h0, ctl_m[edge_l[i] - 7'h01]}, v);
    end
    hop(OP_IRD, 8'hC9, 8'h00, v);
    chk("invalid address", {24'h0, ctl_m[71]}, v);
    hop(OP_DRD, ACTL_OFS, 8'h00, v);
    chk("address/control", 32'hC9, v);
    $display("test indirect banks done");
    for (int k = 0; k < 3; k++)
    begin
      for (int j = 1; j <= IND_DEPTH; j++)
        ind_wr(7'(j), 8'($random(seed)));
      hop(OP_IRD, 8'h01, 8'h00, v);
      chk("control readback", {24'h0, ctl_m[0]}, v);
      en_m = (k != 0);
      hop(OP_DWR, CFG_OFS, {7'h0, en_m}, v);
      hop(OP_DRD, CFG_OFS, 8'h00, v);
      chk("enable bit", {31'h0, en_m}, {31'h0, v[ENABLE_BIT]});
      slots(1500);
      $display("test slot pass %0d done", k);
    end
    results();
  end
  initial
  begin
    #300000;
    n_mismatch++;
    $display("watchdog expired");
    results();
  end
endmodule
